// *** boot_reset_pkg.sv ***
// Constants, types and decode tables shared by the startup controller and its watchdog.
// Assumes a single 50 MHz system clock and strap pads that report both level and float sense.
package boot_reset_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_HOLD_NS = 1000;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDT_TICK_HZ = 32_000;
    localparam int WDT_DIV_CYC = CLK_HZ / WDT_TICK_HZ;
    localparam logic [15:0] WDT_TIMEOUT_RST = 16'hffff;

    // ----------------------------------------------------------------
    // Strap encodings: two bits per pin, float = 2'b10
    // ----------------------------------------------------------------
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;
    localparam logic [1:0] PIN_FLOAT = 2'h2;
    localparam logic [5:0] BOOT_KEY_F00 = 6'h20;
    localparam logic [5:0] BOOT_KEY_F01 = 6'h21;
    localparam logic [5:0] BOOT_KEY_F11 = 6'h25;
    localparam logic [5:0] BOOT_KEY_F0F = 6'h22;
    localparam logic [5:0] BOOT_KEY_F1F = 6'h26;
    localparam logic [5:0] BOOT_KEY_1FF = 6'h1a;
    localparam logic [5:0] BOOT_KEY_0F1 = 6'h09;

    localparam logic [2:0] CLK_SEL_XTAL_19M2 = 3'h0;
    localparam logic [2:0] CLK_SEL_IN_19M2 = 3'h4;
    localparam logic [2:0] CLK_SEL_IN_26M = 3'h5;
    localparam logic [2:0] CLK_SEL_IN_38M4 = 3'h6;
    localparam logic [2:0] CLK_SEL_IN_52M = 3'h7;
    localparam int REF_19M2_KHZ = 19_200;
    localparam int REF_26M_KHZ = 26_000;
    localparam int REF_38M4_KHZ = 38_400;
    localparam int REF_52M_KHZ = 52_000;
    localparam int PLL_TARGET_KHZ = 384_000;
    localparam int PLL_FRAC_BITS = 8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        BOOT_NONE, BOOT_SYNC_MUXED, BOOT_ASYNC_MUXED, BOOT_ASYNC_SRAM,
        BOOT_USB, BOOT_I2C, BOOT_SPI
    } boot_src_t;

    typedef enum logic [2:0] {
        REF_INVALID, REF_XTAL_19M2, REF_IN_19M2, REF_IN_26M, REF_IN_38M4, REF_IN_52M
    } ref_sel_t;

    typedef struct packed {
        logic [2:0] level;
        logic [2:0] floating;
    } strap_pins_t;

    typedef struct packed {
        boot_src_t src;
        logic usb_fallback;
        logic invalid;
    } boot_cfg_t;

    typedef struct packed {
        ref_sel_t sel;
        logic [15:0] pll_mult_q8;
        logic invalid;
    } clk_cfg_t;

    typedef struct packed {
        logic enable;
        logic [15:0] timeout;
        logic irq_en;
        logic wake_en;
        logic reset_en;
        logic use_ext_clk;
    } wdt_ctrl_t;

endpackage : boot_reset_pkg

// *** watchdog_32k.sv ***
// Watchdog counting 32 kHz ticks with interrupt, wakeup and CPU reset on expiry.
// Assumes the external 32 kHz pin is synchronous to clk_i; ticks are taken on its rising edge.
`timescale 1ns/1ps
module watchdog_32k #(
    parameter int DIV_CYC = boot_reset_pkg::WDT_DIV_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire boot_reset_pkg::wdt_ctrl_t ctrl_i,
    input wire logic ext_clk32_i,
    input wire logic kick_i,
    input wire logic standby_i,
    output logic irq_o,
    output logic wake_o,
    output logic cpu_reset_req_o
);
    import boot_reset_pkg::*;

    logic [15:0] div_reg;
    logic ext_prev_reg;
    logic tick;
    logic [15:0] count_reg;
    logic expire;

    // ----------------------------------------------------------------
    // Tick generation
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg <= 16'h0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_clk32_i;
            if (clear_i || div_reg == 16'(DIV_CYC - 1)) begin
                div_reg <= 16'h0;
            end else begin
                div_reg <= div_reg + 16'h1;
            end
        end
    end

    // The tick comes from the external pin or from the internal divider.
    assign tick = ctrl_i.use_ext_clk ? (ext_clk32_i && !ext_prev_reg)
                                     : (div_reg == 16'(DIV_CYC - 1));

    // ----------------------------------------------------------------
    // Counter and expiry
    // ----------------------------------------------------------------
    assign expire = ctrl_i.enable && tick && (count_reg >= ctrl_i.timeout);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= 16'h0;
        end else if (clear_i || !ctrl_i.enable || kick_i || expire) begin
            count_reg <= 16'h0;
        end else if (tick) begin
            count_reg <= count_reg + 16'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            wake_o <= 1'b0;
            cpu_reset_req_o <= 1'b0;
        end else begin
            irq_o <= expire && ctrl_i.irq_en && !clear_i;
            wake_o <= expire && ctrl_i.wake_en && standby_i && !clear_i;
            cpu_reset_req_o <= expire && ctrl_i.reset_en && !clear_i;
        end
    end

endmodule : watchdog_32k

// *** boot_reset_clock_select.sv ***
// Startup controller: reset sequencing, strap decoding for boot source and reference clock, watchdog.
// Assumes all pins are synchronous to clk_i and that boot media report done or failure by pulses.
`timescale 1ns/1ps
module boot_reset_clock_select #(
    parameter int HOLD_CYC = boot_reset_pkg::RESET_HOLD_CYC,
    parameter int WDT_DIV = boot_reset_pkg::WDT_DIV_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire boot_reset_pkg::strap_pins_t boot_source_strap_i,
    input wire boot_reset_pkg::strap_pins_t ref_clock_select_strap_i,
    input wire logic init_cpu_reset_i,
    input wire logic init_device_reset_i,
    input wire logic boot_done_i,
    input wire logic boot_fail_i,
    input wire boot_reset_pkg::wdt_ctrl_t wdt_ctrl_i,
    input wire logic wdt_kick_i,
    input wire logic ext_clk32_i,
    input wire logic standby_i,
    output logic device_reset_o,
    output logic cpu_reset_o,
    output logic firmware_lost_o,
    output logic boot_start_o,
    output boot_reset_pkg::boot_src_t boot_source_o,
    output logic boot_failed_o,
    output logic running_o,
    output boot_reset_pkg::boot_cfg_t boot_cfg_o,
    output boot_reset_pkg::clk_cfg_t clk_cfg_o,
    output logic wdt_irq_o,
    output logic wdt_wake_o
);
    import boot_reset_pkg::*;

    // ----------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------
    function automatic logic [5:0] strap_key(input strap_pins_t pins);
        logic [5:0] key;
        key = 6'h0;
        for (int i = 0; i < 3; i++) begin
            // A floating pin reads as its own symbol, independent of level.
            key[2*i +: 2] = pins.floating[i] ? PIN_FLOAT : (pins.level[i] ? PIN_HIGH : PIN_LOW);
        end
        return key;
    endfunction : strap_key

    function automatic boot_cfg_t decode_boot(input strap_pins_t pins);
        boot_cfg_t cfg;
        logic [5:0] key;
        key = strap_key(pins);
        cfg.src = BOOT_NONE;
        cfg.usb_fallback = 1'b0;
        cfg.invalid = 1'b0;
        if (key == BOOT_KEY_F00) begin
            cfg.src = BOOT_SYNC_MUXED;
        end else if (key == BOOT_KEY_F01) begin
            cfg.src = BOOT_ASYNC_MUXED;
        end else if (key == BOOT_KEY_F0F) begin
            cfg.src = BOOT_ASYNC_SRAM;
        end else if (key == BOOT_KEY_F11) begin
            cfg.src = BOOT_USB;
        end else if (key == BOOT_KEY_F1F) begin
            cfg.src = BOOT_I2C;
            cfg.usb_fallback = 1'b1;
        end else if (key == BOOT_KEY_1FF) begin
            cfg.src = BOOT_I2C;
        end else if (key == BOOT_KEY_0F1) begin
            cfg.src = BOOT_SPI;
            cfg.usb_fallback = 1'b1;
        end else begin
            cfg.invalid = 1'b1;
        end
        return cfg;
    endfunction : decode_boot

    function automatic logic [15:0] pll_mult(input int ref_khz);
        int q;
        // Rounded ratio of the fixed core target to the reference, in Q8.
        q = ((PLL_TARGET_KHZ << PLL_FRAC_BITS) + ref_khz / 2) / ref_khz;
        return q[15:0];
    endfunction : pll_mult

    function automatic clk_cfg_t decode_clk(input strap_pins_t pins);
        clk_cfg_t cfg;
        cfg.sel = REF_INVALID;
        cfg.pll_mult_q8 = 16'h0;
        cfg.invalid = 1'b0;
        if (pins.floating != 3'h0) begin
            cfg.invalid = 1'b1;
        end else if (pins.level == CLK_SEL_XTAL_19M2) begin
            cfg.sel = REF_XTAL_19M2;
            cfg.pll_mult_q8 = pll_mult(REF_19M2_KHZ);
        end else if (pins.level == CLK_SEL_IN_19M2) begin
            cfg.sel = REF_IN_19M2;
            cfg.pll_mult_q8 = pll_mult(REF_19M2_KHZ);
        end else if (pins.level == CLK_SEL_IN_26M) begin
            cfg.sel = REF_IN_26M;
            cfg.pll_mult_q8 = pll_mult(REF_26M_KHZ);
        end else if (pins.level == CLK_SEL_IN_38M4) begin
            cfg.sel = REF_IN_38M4;
            cfg.pll_mult_q8 = pll_mult(REF_38M4_KHZ);
        end else if (pins.level == CLK_SEL_IN_52M) begin
            cfg.sel = REF_IN_52M;
            cfg.pll_mult_q8 = pll_mult(REF_52M_KHZ);
        end else begin
            cfg.invalid = 1'b1;
        end
        return cfg;
    endfunction : decode_clk

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_PIN_RESET, ST_DEV_HOLD, ST_SAMPLE, ST_BOOT_START, ST_BOOT_WAIT,
        ST_RUN, ST_CPU_HOLD, ST_HALT
    } seq_state_t;

    seq_state_t state_reg;
    seq_state_t state_next;
    logic [15:0] hold_reg;
    logic hold_done;
    boot_src_t src_reg;
    logic wdt_reset_req;
    logic wdt_clear;
    boot_cfg_t boot_decoded;

    assign boot_decoded = decode_boot(boot_source_strap_i);
    assign hold_done = (hold_reg == 16'(HOLD_CYC - 1));
    // Watchdog is cleared along with the whole device.
    assign wdt_clear = (state_reg == ST_PIN_RESET) || (state_reg == ST_DEV_HOLD);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_PIN_RESET: begin
                if (reset_pin_n_i) begin
                    state_next = ST_DEV_HOLD;
                end
            end
            ST_DEV_HOLD: begin
                if (hold_done) begin
                    state_next = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                state_next = ST_BOOT_START;
            end
            ST_BOOT_START: begin
                state_next = (src_reg == BOOT_NONE) ? ST_HALT : ST_BOOT_WAIT;
            end
            ST_BOOT_WAIT: begin
                if (boot_done_i) begin
                    state_next = ST_RUN;
                end else if (boot_fail_i) begin
                    state_next = (boot_cfg_o.usb_fallback && src_reg != BOOT_USB) ? ST_BOOT_START : ST_HALT;
                end
            end
            ST_RUN: begin
                if (init_device_reset_i) begin
                    state_next = ST_DEV_HOLD;
                end else if (init_cpu_reset_i || wdt_reset_req) begin
                    state_next = ST_CPU_HOLD;
                end
            end
            ST_CPU_HOLD: begin
                if (hold_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_HALT: begin
                if (init_device_reset_i) begin
                    state_next = ST_DEV_HOLD;
                end
            end
            default: begin
                state_next = ST_PIN_RESET;
            end
        endcase
        // The reset pin overrides everything.
        if (!reset_pin_n_i) begin
            state_next = ST_PIN_RESET;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_PIN_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_reg <= 16'h0;
        end else if (state_next != state_reg) begin
            hold_reg <= 16'h0;
        end else if ((state_reg == ST_DEV_HOLD || state_reg == ST_CPU_HOLD) && !hold_done) begin
            hold_reg <= hold_reg + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_cfg_o <= '0;
            clk_cfg_o <= '0;
        end else if (state_reg == ST_SAMPLE) begin
            boot_cfg_o <= boot_decoded;
            clk_cfg_o <= decode_clk(ref_clock_select_strap_i);
        end
    end

    // Active source; switches to USB when a fallback-enabled boot fails.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_reg <= BOOT_NONE;
        end else if (state_reg == ST_SAMPLE) begin
            src_reg <= boot_decoded.src;
        end else if (state_reg == ST_BOOT_WAIT && !boot_done_i && boot_fail_i && boot_cfg_o.usb_fallback) begin
            src_reg <= BOOT_USB;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            device_reset_o <= 1'b1;
            cpu_reset_o <= 1'b1;
            running_o <= 1'b0;
            boot_start_o <= 1'b0;
            boot_source_o <= BOOT_NONE;
        end else begin
            device_reset_o <= (state_next == ST_PIN_RESET) || (state_next == ST_DEV_HOLD);
            cpu_reset_o <= (state_next != ST_RUN);
            running_o <= (state_next == ST_RUN);
            boot_start_o <= (state_next == ST_BOOT_START);
            boot_source_o <= (state_reg == ST_SAMPLE) ? boot_decoded.src
                : (state_next == ST_BOOT_START && state_reg == ST_BOOT_WAIT) ? BOOT_USB : src_reg;
        end
    end

    // Firmware is lost by any whole-device reset, and never by a CPU-only reset.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            firmware_lost_o <= 1'b1;
        end else if (state_next == ST_PIN_RESET || state_next == ST_DEV_HOLD) begin
            firmware_lost_o <= 1'b1;
        end else if (state_reg == ST_BOOT_WAIT && state_next == ST_RUN) begin
            firmware_lost_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_failed_o <= 1'b0;
        end else if (state_next == ST_DEV_HOLD || state_next == ST_PIN_RESET) begin
            boot_failed_o <= 1'b0;
        end else if (state_next == ST_HALT) begin
            boot_failed_o <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    watchdog_32k #(
        .DIV_CYC(WDT_DIV)
    ) u_wdt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(wdt_clear),
        .ctrl_i(wdt_ctrl_i),
        .ext_clk32_i(ext_clk32_i),
        .kick_i(wdt_kick_i),
        .standby_i(standby_i),
        .irq_o(wdt_irq_o),
        .wake_o(wdt_wake_o),
        .cpu_reset_req_o(wdt_reset_req)
    );

endmodule : boot_reset_clock_select

// *** board_model.sv ***
// Board side of the startup controller: strap pads and boot media.
// Assumes the bench sets strap keys (2 bits a pin, 2'h2 floating) and which boot sources fail.
`timescale 1ns/1ps
module board_model (
    input wire logic clk_i,
    input wire logic [5:0] boot_key_i,
    input wire logic [5:0] clk_key_i,
    input wire logic [7:0] fail_mask_i,
    input wire logic boot_start_i,
    input wire boot_reset_pkg::boot_src_t boot_source_i,
    output boot_reset_pkg::strap_pins_t boot_strap_o,
    output boot_reset_pkg::strap_pins_t clk_strap_o,
    output logic boot_done_o,
    output logic boot_fail_o
);
    import boot_reset_pkg::*;
    logic flip = 1'b0;
    logic [3:0] cnt = 4'h0;
    boot_src_t src = BOOT_NONE;

    // A floating pad shows a level that changes every cycle, so it must be ignored.
    always_ff @(posedge clk_i) begin
        flip <= ~flip;
    end
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            boot_strap_o.floating[k] = boot_key_i[2*k+1];
            boot_strap_o.level[k] = boot_key_i[2*k+1] ? flip : boot_key_i[2*k];
            clk_strap_o.floating[k] = clk_key_i[2*k+1];
            clk_strap_o.level[k] = clk_key_i[2*k+1] ? flip : clk_key_i[2*k];
        end
    end

    // The medium answers each boot attempt six cycles later with done or failure.
    always_ff @(posedge clk_i) begin
        boot_done_o <= 1'b0;
        boot_fail_o <= 1'b0;
        if (boot_start_i) begin
            cnt <= 4'h6;
            src <= boot_source_i;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                boot_fail_o <= fail_mask_i[src];
                boot_done_o <= !fail_mask_i[src];
            end
        end
    end
endmodule : board_model

// *** boot_reset_monitor.sv ***
// Port checker of the startup controller: resets, strap decode, watchdog.
// Assumes straps stay steady around reset release; bound to the controller below.
`timescale 1ns/1ps
module boot_reset_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire boot_reset_pkg::strap_pins_t boot_source_strap_i,
    input wire boot_reset_pkg::strap_pins_t ref_clock_select_strap_i,
    input wire logic init_cpu_reset_i,
    input wire logic init_device_reset_i,
    input wire boot_reset_pkg::wdt_ctrl_t wdt_ctrl_i,
    input wire logic standby_i,
    input wire logic device_reset_o,
    input wire logic cpu_reset_o,
    input wire logic firmware_lost_o,
    input wire logic running_o,
    input wire boot_reset_pkg::boot_cfg_t boot_cfg_o,
    input wire boot_reset_pkg::clk_cfg_t clk_cfg_o,
    input wire logic wdt_irq_o,
    input wire logic wdt_wake_o
);
    import boot_reset_pkg::*;
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    function automatic logic [5:0] key_of(strap_pins_t s);
        logic [5:0] k6;
        for (int k = 0; k < 3; k++) k6[2*k +: 2] = s.floating[k] ? 2'h2 : {1'b0, s.level[k]};
        return k6;
    endfunction : key_of
    function automatic boot_src_t exp_src(logic [5:0] k);
        case (k)
            6'h20: return BOOT_SYNC_MUXED;
            6'h21: return BOOT_ASYNC_MUXED;
            6'h25: return BOOT_USB;
            6'h22: return BOOT_ASYNC_SRAM;
            6'h26, 6'h1a: return BOOT_I2C;
            6'h09: return BOOT_SPI;
            default: return BOOT_NONE;
        endcase
    endfunction : exp_src
    function automatic ref_sel_t exp_sel(strap_pins_t s);
        if (|s.floating || (s.level != 3'h0 && !s.level[2])) return REF_INVALID;
        return (s.level == 3'h0) ? REF_XTAL_19M2 : ref_sel_t'(3'h2 + {1'b0, s.level[1:0]});
    endfunction : exp_sel

    pin_reset_a: assert property
        (!reset_pin_n_i |=> device_reset_o && cpu_reset_o && !running_o) else $error("pin reset missed");
    soft_cpu_a: assert property
        (running_o && init_cpu_reset_i && !init_device_reset_i && reset_pin_n_i
         |=> cpu_reset_o && !device_reset_o && !firmware_lost_o) else $error("cpu soft reset wrong");
    soft_dev_a: assert property
        (running_o && init_device_reset_i && reset_pin_n_i |=> device_reset_o && firmware_lost_o)
        else $error("device soft reset wrong");
    fw_lost_a: assert property (device_reset_o |-> firmware_lost_o) else $error("firmware kept");
    cpu_run_a: assert property (!cpu_reset_o |-> running_o && !device_reset_o) else $error("cpu freed early");
    boot_decode_a: assert property
        ($fell(device_reset_o) |=> boot_cfg_o.src == exp_src(key_of(boot_source_strap_i)))
        else $error("boot source decode wrong");
    clk_decode_a: assert property
        ($fell(device_reset_o) |=> clk_cfg_o.invalid == (exp_sel(ref_clock_select_strap_i) == REF_INVALID)
         && (clk_cfg_o.invalid || clk_cfg_o.sel == exp_sel(ref_clock_select_strap_i))) else $error("clock decode wrong");
    cfg_hold_a: assert property
        (!device_reset_o && !$past(device_reset_o) && !$past(device_reset_o, 2)
         |-> $stable(boot_cfg_o) && $stable(clk_cfg_o))
        else $error("strap config changed");
    wdt_off_a: assert property
        ((!wdt_ctrl_i.enable) [*2] |-> !wdt_irq_o && !wdt_wake_o) else $error("disabled watchdog fired");
    wdt_irq_a: assert property
        (wdt_irq_o |-> $past(wdt_ctrl_i.irq_en) && $past(wdt_ctrl_i.enable)) else $error("stray watchdog irq");
    wdt_wake_a: assert property
        (wdt_irq_o && $past(standby_i) && $past(wdt_ctrl_i.wake_en) |-> wdt_wake_o) else $error("wake missed");

    cover property ($rose(running_o));
    cover property ($rose(cpu_reset_o) && !device_reset_o);
    cover property (wdt_irq_o && wdt_wake_o);
endmodule : boot_reset_monitor

bind boot_reset_clock_select boot_reset_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
    .reset_pin_n_i(reset_pin_n_i), .boot_source_strap_i(boot_source_strap_i),
    .ref_clock_select_strap_i(ref_clock_select_strap_i), .init_cpu_reset_i(init_cpu_reset_i),
    .init_device_reset_i(init_device_reset_i), .wdt_ctrl_i(wdt_ctrl_i), .standby_i(standby_i),
    .device_reset_o(device_reset_o), .cpu_reset_o(cpu_reset_o), .firmware_lost_o(firmware_lost_o),
    .running_o(running_o), .boot_cfg_o(boot_cfg_o), .clk_cfg_o(clk_cfg_o), .wdt_irq_o(wdt_irq_o),
    .wdt_wake_o(wdt_wake_o));

// *** test_boot_reset_clock_select.sv ***
// Self-checking bench of the startup controller with the board model on its far side.
// Assumes hold and divider shortened to 4; stimulus changes at the falling clock edge.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_boot_reset_clock_select;
    import boot_reset_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pin_n = 1'b1;
    logic init_cpu = 1'b0;
    logic init_dev = 1'b0;
    logic ext_clk = 1'b0;
    logic standby = 1'b0;
    logic [5:0] boot_key = 6'h25;
    logic [5:0] clk_key = 6'h00;
    logic [7:0] fail_mask = 8'h00;
    wdt_ctrl_t wdt = '0;
    strap_pins_t bstrap;
    strap_pins_t cstrap;
    logic done, fail, dev_rst, cpu_rst, fw_lost, bstart, bfailed, running, irq, wake;
    boot_src_t bsrc;
    boot_cfg_t bcfg;
    clk_cfg_t ccfg;
    int n_fail = 0;
    int check_count = 0;
    logic [5:0] bkeys[7] = '{6'h20, 6'h21, 6'h25, 6'h22, 6'h26, 6'h1a, 6'h09};
    boot_src_t bexp[7] = '{BOOT_SYNC_MUXED, BOOT_ASYNC_MUXED, BOOT_USB, BOOT_ASYNC_SRAM, BOOT_I2C, BOOT_I2C, BOOT_SPI};
    logic fb_exp[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [5:0] ckeys[5] = '{6'h00, 6'h10, 6'h11, 6'h14, 6'h15};
    ref_sel_t cexp[5] = '{REF_XTAL_19M2, REF_IN_19M2, REF_IN_26M, REF_IN_38M4, REF_IN_52M};
    logic [15:0] mexp[5] = '{16'h1400, 16'h1400, 16'h0ec5, 16'h0a00, 16'h0762};

    always #10 clk_i = ~clk_i;

    boot_reset_clock_select #(.HOLD_CYC(4), .WDT_DIV(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .reset_pin_n_i(pin_n), .boot_source_strap_i(bstrap), .ref_clock_select_strap_i(cstrap),
        .init_cpu_reset_i(init_cpu), .init_device_reset_i(init_dev), .boot_done_i(done), .boot_fail_i(fail),
        .wdt_ctrl_i(wdt), .wdt_kick_i(1'b0), .ext_clk32_i(ext_clk), .standby_i(standby),
        .device_reset_o(dev_rst), .cpu_reset_o(cpu_rst), .firmware_lost_o(fw_lost), .boot_start_o(bstart),
        .boot_source_o(bsrc), .boot_failed_o(bfailed), .running_o(running), .boot_cfg_o(bcfg),
        .clk_cfg_o(ccfg), .wdt_irq_o(irq), .wdt_wake_o(wake));
    board_model i_board (.clk_i(clk_i), .boot_key_i(boot_key), .clk_key_i(clk_key), .fail_mask_i(fail_mask),
        .boot_start_i(bstart), .boot_source_i(bsrc), .boot_strap_o(bstrap), .clk_strap_o(cstrap),
        .boot_done_o(done), .boot_fail_o(fail));

    task automatic tick(int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    task automatic wait_run;
        repeat (100) if (!running) @(negedge clk_i);
    endtask : wait_run
    task automatic hard_boot(logic [5:0] bk, logic [5:0] ck);
        boot_key = bk;
        clk_key = ck;
        pin_n = 1'b0;
        tick(3);
        pin_n = 1'b1;
        tick(1);
        repeat (100) if (!(bstart || bfailed)) @(negedge clk_i);
    endtask : hard_boot
    task automatic pulse_init(logic dev);
        init_dev = dev;
        init_cpu = !dev;
        tick(1);
        init_dev = 1'b0;
        init_cpu = 1'b0;
    endtask : pulse_init
    task automatic quiet(int n);
        logic seen = 1'b0;
        repeat (n) begin
            seen |= irq | wake;
            tick(1);
        end
        `CHK(seen, 1'b0)
    endtask : quiet
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // Cuts a hang short after twenty thousand cycles.
    initial begin
        #400000;
        n_fail++;
        final_report;
    end

    initial begin
        tick(10);
        rst_i = 1'b0;
        for (int i = 0; i < 7; i++) begin
            hard_boot(bkeys[i], ckeys[i % 5]);
            `CHK(bsrc, bexp[i])
            `CHK(bcfg.src, bexp[i])
            `CHK(bcfg.usb_fallback, fb_exp[i])
            `CHK(ccfg.sel, cexp[i % 5])
            `CHK(ccfg.pll_mult_q8, mexp[i % 5])
            `CHK({bstart, fw_lost}, 2'h3)
            wait_run;
            `CHK({running, cpu_rst, fw_lost}, 3'h4)
        end
        $display("decode test done");
        fail_mask = 8'h60;
        for (int i = 4; i < 7; i++) begin
            hard_boot(bkeys[i], 6'h00);
            tick(1);
            repeat (100) if (!(bstart || bfailed)) @(negedge clk_i);
            if (i == 5) `CHK({bfailed, running}, 2'h2)
            else `CHK(bsrc, BOOT_USB)
        end
        fail_mask = 8'h00;
        hard_boot(6'h00, 6'h02);
        repeat (100) if (!bfailed) @(negedge clk_i);
        `CHK({bfailed, bcfg.invalid, ccfg.invalid}, 3'h7)
        pulse_init(1'b1);
        `CHK(dev_rst, 1'b1)
        $display("fallback test done");
        hard_boot(6'h25, 6'h15);
        wait_run;
        boot_key = 6'h20;
        clk_key = 6'h00;
        pulse_init(1'b0);
        `CHK({dev_rst, cpu_rst, fw_lost, running}, 4'h4)
        `CHK(bcfg.src, BOOT_USB)
        wait_run;
        `CHK({running, fw_lost}, 2'h2)
        pulse_init(1'b1);
        `CHK({dev_rst, fw_lost}, 2'h3)
        repeat (100) if (!bstart) @(negedge clk_i);
        `CHK(bcfg.src, BOOT_SYNC_MUXED)
        `CHK(ccfg.sel, REF_XTAL_19M2)
        wait_run;
        $display("soft reset test done");
        standby = 1'b1;
        wdt = '{1'b1, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b0};
        repeat (40) if (!irq) @(negedge clk_i);
        `CHK({irq, wake, running}, 3'h7)
        standby = 1'b0;
        tick(1);
        repeat (40) if (!irq) @(negedge clk_i);
        `CHK({irq, wake}, 2'h2)
        wdt.enable = 1'b0;
        tick(2);
        quiet(40);
        wdt = '{1'b1, 16'h0001, 1'b1, 1'b0, 1'b0, 1'b1};
        quiet(40);
        for (int k = 0; k < 40 && !irq; k++) begin
            ext_clk = ~ext_clk;
            tick(1);
        end
        `CHK(irq, 1'b1)
        wdt = '{1'b1, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b0};
        repeat (40) if (!cpu_rst) @(negedge clk_i);
        `CHK({cpu_rst, dev_rst, fw_lost}, 3'h4)
        wdt.enable = 1'b0;
        wait_run;
        `CHK(running, 1'b1)
        $display("watchdog test done");
        final_report;
    end
endmodule : test_boot_reset_clock_select
